// ---- design/sonet_tx_byte_serializer.sv ----
/*
 * Transmit byte serializer: byte capture, byte clock pin, bit timing source
 * selection and MSB-first serialization onto a differential output.
 * Assumes all inputs are synchronous to clk; clk models the serial clock and
 * the analog clock multiplier is reduced to a per-rate bit divider.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - One byte per byte-clock cycle is taken from the 8-bit bus and sent as a serial stream.
// - The serial bit rate follows the rate mode, the low rate being a quarter of the high rate.
// - The byte clock is the serial bit clock divided by eight and is offered to the framer.
// - In output mode each byte is captured from the bus on the rising edge of the byte clock.
// - With the direction select low the pin is an input and the bus is sampled on the framer clock.
// - In input mode bytes cross from the framer clock to the transmit timing without loss.
// - Each byte leaves most significant bit first, bit 7 down to bit 0.
// - The serial clock is synthesized from a high or low reference according to rate mode.
// - The two reference inputs are combined by exclusive-NOR, the unused one tied low.
// - Loop timing replaces the synthesized bit timing with the recovered receive clock.
module sonet_tx_byte_serializer
    import tx_serializer_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] tx_parallel_data,
    input wire logic byte_clock_direction_select,
    input wire logic tx_byte_clock_pin_in,
    output logic tx_byte_clock_pin_out,
    output logic tx_byte_clock_pin_oe,
    input wire logic rate_mode_sts12,
    input wire logic diff_reference_clock,
    input wire logic single_ended_reference_clock,
    output logic reference_clock_level,
    input wire logic loop_timing_select,
    input wire logic recovered_clock,
    output diff_out_t serial_tx_output,
    output logic byte_underrun
);

    // ------------------------------------------------------------
    // Clock multiplier and bit timing
    // ------------------------------------------------------------
    logic [1:0] div_cnt_r, div_cnt_nxt;
    logic ref_level_r, ref_level_nxt;
    logic rec_prev_r, rec_prev_nxt;
    logic bit_tick;
    logic [1:0] div_limit;

    always_comb
    begin
        ref_level_nxt = ~(diff_reference_clock ^ single_ended_reference_clock);
        div_limit = rate_mode_sts12 ? BIT_DIV_STS12 : BIT_DIV_STS3;
        div_cnt_nxt = (div_cnt_r >= div_limit) ? 2'h0 : div_cnt_r + 2'h1;
        rec_prev_nxt = recovered_clock;
        // Loop timing hands the bit cadence to the recovered clock edges
        if (loop_timing_select)
        begin
            bit_tick = recovered_clock & ~rec_prev_r;
        end
        else
        begin
            bit_tick = (div_cnt_r >= div_limit);
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_cnt_r <= 2'h0;
            ref_level_r <= 1'b0;
            rec_prev_r <= 1'b0;
        end
        else
        begin
            div_cnt_r <= div_cnt_nxt;
            ref_level_r <= ref_level_nxt;
            rec_prev_r <= rec_prev_nxt;
        end
    end

    // ------------------------------------------------------------
    // Byte clock pin and framer-clocked capture
    // ------------------------------------------------------------
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic byte_clk_r, byte_clk_nxt;
    logic pin_oe_r, pin_oe_nxt;
    logic pin_prev_r, pin_prev_nxt;
    logic [7:0] hold_r, hold_nxt;
    logic hold_valid_r, hold_valid_nxt;
    logic load;
    logic framer_edge;

    assign load = bit_tick && (bit_cnt_r == 3'(BYTE_BITS - 1));

    always_comb
    begin
        bit_cnt_nxt = bit_tick ? bit_cnt_r + 3'h1 : bit_cnt_r;
        // High for bits 0..3, low for 4..7: rises exactly at each load
        byte_clk_nxt = (bit_cnt_nxt < 3'(BYTE_CLOCK_DIV / 2));
        pin_oe_nxt = byte_clock_direction_select;
        pin_prev_nxt = tx_byte_clock_pin_in;
        framer_edge = ~pin_oe_r & tx_byte_clock_pin_in & ~pin_prev_r;
        hold_nxt = hold_r;
        hold_valid_nxt = hold_valid_r;
        if (load)
        begin
            hold_valid_nxt = 1'b0;
        end
        // A framer edge in the load cycle wins over the clear
        if (framer_edge)
        begin
            hold_nxt = tx_parallel_data;
            hold_valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bit_cnt_r <= BIT_CNT_RST;
            byte_clk_r <= 1'b0;
            pin_oe_r <= 1'b1;
            pin_prev_r <= 1'b0;
            hold_r <= BYTE_RST;
            hold_valid_r <= 1'b0;
        end
        else
        begin
            bit_cnt_r <= bit_cnt_nxt;
            byte_clk_r <= byte_clk_nxt;
            pin_oe_r <= pin_oe_nxt;
            pin_prev_r <= pin_prev_nxt;
            hold_r <= hold_nxt;
            hold_valid_r <= hold_valid_nxt;
        end
    end

    assign tx_byte_clock_pin_out = byte_clk_r;
    assign tx_byte_clock_pin_oe = pin_oe_r;
    assign reference_clock_level = ref_level_r;

    // ------------------------------------------------------------
    // Parallel to serial converter
    // ------------------------------------------------------------
    // One holding byte is enough because both sides run at the same mean
    // rate; a framer edge that lands in the load cycle is kept, not dropped.
    logic [7:0] shift_r, shift_nxt;
    logic ser_r, ser_nxt;
    logic underrun_r, underrun_nxt;
    logic [7:0] src;

    always_comb
    begin
        underrun_nxt = underrun_r;
        if (pin_oe_r)
        begin
            src = tx_parallel_data;
        end
        else if (hold_valid_r)
        begin
            src = hold_r;
        end
        else
        begin
            src = IDLE_BYTE;
        end
        shift_nxt = shift_r;
        ser_nxt = ser_r;
        if (load)
        begin
            ser_nxt = src[7];
            shift_nxt = {src[6:0], 1'b0};
            underrun_nxt = ~pin_oe_r & ~hold_valid_r;
        end
        else if (bit_tick)
        begin
            ser_nxt = shift_r[7];
            shift_nxt = {shift_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shift_r <= BYTE_RST;
            ser_r <= 1'b0;
            underrun_r <= 1'b0;
        end
        else
        begin
            shift_r <= shift_nxt;
            ser_r <= ser_nxt;
            underrun_r <= underrun_nxt;
        end
    end

    assign serial_tx_output.p = ser_r;
    assign serial_tx_output.n = ~ser_r;
    assign byte_underrun = underrun_r;

endmodule // sonet_tx_byte_serializer

`default_nettype wire

// ---- design/tx_serializer_pkg.sv ----
/*
 * Shared constants and carrier types for the transmit byte serializer.
 * Assumes one 10 MHz system clock that stands in for the synthesized serial clock.
 */
package tx_serializer_pkg;

    // ------------------------------------------------------------
    // Rates and clock ratios
    // ------------------------------------------------------------
    localparam int unsigned SERIAL_KHZ_STS12 = 622080;
    localparam int unsigned SERIAL_KHZ_STS3 = 155520;
    localparam int unsigned REF_KHZ_HIGH = 77760;
    localparam int unsigned REF_KHZ_LOW = 19440;
    localparam int unsigned BYTE_BITS = 8;
    // Serial clock to byte clock ratio
    localparam int unsigned BYTE_CLOCK_DIV = BYTE_BITS;
    // Divider limits, one less than the system clocks per serial bit in each rate mode (622.08 / 155.52 = 4)
    localparam logic [1:0] BIT_DIV_STS12 = 2'h0;
    localparam logic [1:0] BIT_DIV_STS3 = 2'(SERIAL_KHZ_STS12 / SERIAL_KHZ_STS3 - 1);

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] BIT_CNT_RST = 3'h7;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Byte sent when the framer has not supplied one in time
    localparam logic [7:0] IDLE_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic p;
        logic n;
    } diff_out_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

endpackage

// ---- testbench/framer_model.sv ----
/* Framer stand-in driving the transmit bus.
   Assumes the bench resolves the byte clock pin and hands its level back. */
`timescale 1ns/1ps
`default_nettype none
module framer_model (
    input wire logic clk,
    input wire logic drive_clk,
    input wire logic run,
    input wire logic pin,
    output logic own_clk,
    output logic [7:0] data
);
    logic [2:0] cnt_r = 3'h0;
    logic seen_r = 1'b0;
    initial own_clk = 1'b0;
    initial data = 8'h5a;
    always @(posedge clk)
    begin
        seen_r <= pin;
        cnt_r <= run ? cnt_r + 3'h1 : 3'h0;
        // Own clock stands still when stopped
        own_clk <= run && drive_clk && cnt_r < 3'h4;
        // Bus moves half a byte after its own clock edge, or one clock after a byte clock rise
        if (drive_clk ? run && cnt_r == 3'h4 : pin && !seen_r)
            data <= data + 8'h01;
    end
endmodule // framer_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
/* Self-checking bench for the transmit byte serializer.
   Assumes the framer model owns the data bus. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import tx_serializer_pkg::*;
;
    logic clk, bc, oe, lvl, udr, fclk;
    logic rst = 1'b1, sel = 1'b1, rate = 1'b1, loop = 1'b0, dr = 1'b0, sr = 1'b1, run = 1'b1;
    logic [7:0] data;
    logic [7:0] b;
    logic [1:0] rcc = 2'h0;
    diff_out_t ser;
    int err_count = 0;
    int checked = 0;
    wire logic rc = rcc[1];
    wire logic pin = oe ? bc : fclk;
    sonet_tx_byte_serializer dut_u (.clk(clk), .sys_rst(rst), .tx_parallel_data(data),
        .byte_clock_direction_select(sel), .tx_byte_clock_pin_in(pin), .tx_byte_clock_pin_out(bc),
        .tx_byte_clock_pin_oe(oe), .rate_mode_sts12(rate), .diff_reference_clock(dr),
        .single_ended_reference_clock(sr), .reference_clock_level(lvl), .loop_timing_select(loop),
        .recovered_clock(rc), .serial_tx_output(ser), .byte_underrun(udr));
    framer_model frm_u (.clk(clk), .drive_clk(!sel), .run(run), .pin(pin), .own_clk(fclk), .data(data));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) rcc <= rcc + 2'h1;
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_lvl(input logic v);
        for (int t = 0; bc !== v; t++)
        begin
            if (t > 300)
            begin
                err_count++;
                conclude();
            end
            @(negedge clk);
        end
    endtask
    task automatic setup(input logic s, input logic r, input logic l, input logic f);
        @(posedge clk);
        rst <= 1'b1;
        sel <= s;
        rate <= r;
        loop <= l;
        run <= f;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask
    // Collects n back-to-back bytes; the first two may predate the framer's first byte
    task automatic rx(input int n, input int per, input bit seq);
        logic [7:0] prev;
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        for (int i = 0; i < n; i++)
        begin
            repeat (8)
            begin
                b = {b[6:0], ser.p};
                repeat (per) @(negedge clk);
            end
            if (seq && i > 1)
                chk(b, prev + 8'h01);
            prev = b;
        end
    endtask
    task automatic t_out();
        setup(1'b1, 1'b1, 1'b0, 1'b1);
        rx(6, 1, 1'b1);
        chk({7'h0, oe}, 8'h01);
        setup(1'b1, 1'b0, 1'b0, 1'b1);
        rx(4, 4, 1'b1);
        setup(1'b1, 1'b1, 1'b1, 1'b1);
        rx(4, 4, 1'b1);
        $display("output modes done");
    endtask
    task automatic t_in();
        setup(1'b0, 1'b1, 1'b0, 1'b0);
        rx(2, 1, 1'b0);
        chk(b, IDLE_BYTE);
        chk({7'h0, udr}, 8'h01);
        @(posedge clk);
        run <= 1'b1;
        rx(6, 1, 1'b1);
        chk({7'h0, udr | oe}, 8'h00);
        $display("input mode done");
    endtask
    task automatic t_ref();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            {dr, sr} <= i[1:0];
            @(posedge clk);
            @(negedge clk);
            chk({7'h0, lvl}, {7'h0, ~^i[1:0]});
        end
        $display("reference done");
    endtask
    initial
    begin
        t_out();
        t_in();
        t_ref();
        conclude();
    end
endmodule // tb_top
`default_nettype wire

// ---- testbench/tx_serializer_monitor.sv ----
/* Port checker for the transmit serializer, bound to its top.
   Assumes one domain: clk with sys_rst. */
`timescale 1ns/1ps
`default_nettype none
module tx_serializer_monitor
    import tx_serializer_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] tx_parallel_data,
    input wire logic byte_clock_direction_select,
    input wire logic tx_byte_clock_pin_out,
    input wire logic tx_byte_clock_pin_oe,
    input wire logic rate_mode_sts12,
    input wire logic diff_reference_clock,
    input wire logic single_ended_reference_clock,
    input wire logic reference_clock_level,
    input wire logic loop_timing_select,
    input wire logic recovered_clock,
    input wire diff_out_t serial_tx_output,
    input wire logic byte_underrun
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic p = serial_tx_output.p;
    wire logic bc = tx_byte_clock_pin_out;
    wire logic [7:0] d = tx_parallel_data;
    sequence load_s;
        $rose(bc) && rate_mode_sts12 && !loop_timing_select && tx_byte_clock_pin_oe;
    endsequence
    // Bit k of the byte taken at the load edge shows 7-k samples after the match, bit 7 first
    sequence msb_s;
        p == $past(d[7]) ##1 p == $past(d[6], 2) ##1 p == $past(d[5], 3) ##1 p == $past(d[4], 4)
        ##1 p == $past(d[3], 5) ##1 p == $past(d[2], 6) ##1 p == $past(d[1], 7) ##1 p == $past(d[0], 8);
    endsequence
    msb_first_a: assert property (load_s |-> msb_s)
        else $error("bit order wrong");
    byte_period_a: assert property (load_s |-> bc[*4] ##1 !bc[*4] ##1 bc)
        else $error("byte clock period wrong");
    slow_bit_a: assert property ($rose(bc) && !rate_mode_sts12 && !loop_timing_select
        |-> ##1 $stable(p)[*3] ##12 bc ##1 !bc) else $error("slow rate timing wrong");
    // The edge that leaves reset still loads the reset value, so it is skipped
    pin_dir_a: assert property ($past(!sys_rst) |-> tx_byte_clock_pin_oe == $past(byte_clock_direction_select))
        else $error("pin direction wrong");
    diff_pair_a: assert property (serial_tx_output.n == !p)
        else $error("pair not complementary");
    ref_xnor_a: assert property ($past(!sys_rst) |-> reference_clock_level ==
        ($past(diff_reference_clock) ~^ $past(single_ended_reference_clock))) else $error("reference xnor wrong");
    idle_fill_a: assert property ($rose(byte_underrun) && rate_mode_sts12 |-> !p[*8])
        else $error("underrun byte not idle");
    loop_tick_a: assert property (loop_timing_select && $past(loop_timing_select, 2) && $changed(p)
        |-> $past(recovered_clock) && !$past(recovered_clock, 2)) else $error("bit moved off recovered edge");
endmodule // tx_serializer_monitor
bind sonet_tx_byte_serializer tx_serializer_monitor mon_u (.*);
`default_nettype wire
